/* core/ssx_pkg.sv */
/*
 ssx_pkg: shared constants for the skip, swap, table read and xor execution block.
 assumes a 40 MHz pclk and an apb master for software access.
*/
package ssx_pkg;
   // register byte offsets
   localparam logic [11:0] SSX_ACC_OFF = 12'h000;
   localparam logic [11:0] SSX_MEM_OFF = 12'h004;
   localparam logic [11:0] SSX_TPL_OFF = 12'h008;
   localparam logic [11:0] SSX_TPH_OFF = 12'h00C;
   localparam logic [11:0] SSX_TBH_OFF = 12'h010;
   localparam logic [11:0] SSX_CMD_OFF = 12'h014;
   localparam logic [11:0] SSX_STS_OFF = 12'h018;
   localparam logic [11:0] SSX_PAGE_OFF = 12'h01C;
   // command register fields
   localparam int SSX_OP_LSB = 0;
   localparam int SSX_BIT_LSB = 4;
   localparam int SSX_IMM_LSB = 8;
   // status register fields
   localparam int SSX_ST_Z = 0;
   localparam int SSX_ST_SKIP = 1;
   localparam int SSX_ST_BUSY = 2;
   // reset values
   localparam logic [7:0] SSX_BYTE_RST = 8'h00;
   // cycles of a skipping instruction
   localparam logic [1:0] SSX_SKIP_CYCLES = 2'h2;
   typedef enum logic [3:0] {
      SSX_NOP,
      SSX_NIBBLE_SWAP_TO_ACC,
      SSX_SKIP_IF_ZERO,
      SSX_COPY_SKIP_IF_ZERO,
      SSX_SKIP_IF_BIT_ZERO,
      SSX_TABLE_READ_SPECIFIC_PAGE,
      SSX_TABLE_READ_CURRENT_PAGE,
      SSX_TABLE_READ_LAST_PAGE,
      SSX_XOR_TO_ACC,
      SSX_XOR_TO_MEMORY,
      SSX_XOR_IMM
   } ssx_op_t;
   typedef enum {SSX_IDLE, SSX_TABLE, SSX_DUMMY} ssx_state_t;
endpackage

/* core/ssx_alu.sv */
/*
 ssx_alu: combinational result path for the swap, skip and xor operations.
 assumes operands are stable for the cycle in which the result is used.
*/
`timescale 1ns/1ps
module ssx_alu
   import ssx_pkg::*;
(
   // operation and operands
   input wire ssx_op_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem,
   input wire logic [7:0] imm,
   input wire logic [2:0] bit_sel,
   // results
   output logic [7:0] acc_res,
   output logic acc_we,
   output logic [7:0] mem_res,
   output logic mem_we,
   output logic z_res,
   output logic z_we,
   output logic skip
);
   logic [7:0] x;

   always_comb begin
      x = 8'h00;
      acc_res = acc;
      acc_we = 1'b0;
      mem_res = mem;
      mem_we = 1'b0;
      z_we = 1'b0;
      skip = 1'b0;
      case (op)
         SSX_NIBBLE_SWAP_TO_ACC: begin
            acc_res = {mem[3:0], mem[7:4]};
            acc_we = 1'b1;
         end
         SSX_SKIP_IF_ZERO: begin
            skip = (mem == 8'h00);
         end
         SSX_COPY_SKIP_IF_ZERO: begin
            acc_res = mem;
            acc_we = 1'b1;
            skip = (mem == 8'h00);
         end
         SSX_SKIP_IF_BIT_ZERO: begin
            skip = ~mem[bit_sel];
         end
         SSX_XOR_TO_ACC: begin
            x = acc ^ mem;
            acc_res = x;
            acc_we = 1'b1;
            z_we = 1'b1;
         end
         SSX_XOR_TO_MEMORY: begin
            x = acc ^ mem;
            mem_res = x;
            mem_we = 1'b1;
            z_we = 1'b1;
         end
         SSX_XOR_IMM: begin
            x = acc ^ imm;
            acc_res = x;
            acc_we = 1'b1;
            z_we = 1'b1;
         end
         default: begin
            x = 8'h00;
         end
      endcase
      z_res = (x == 8'h00);
   end
endmodule

/* core/ssx_exec.sv */
/*
 ssx_exec: executes swap, zero and bit skips, table reads and xor forms.
 assumes an apb master; program memory is a combinational read port owned outside, data sampled in the fetch cycle.
*/
// Decided for this implementation: the address map and the APB slave port.
// Summary of operation
// - nibble swap loads acc low from mem high and acc high from mem low, mem and flags kept.
// - skip if zero skips the next instruction when the memory byte is zero, no flags changed.
// - a taken skip adds one dummy cycle so the skipping instruction takes two cycles.
// - copy and skip if zero copies memory to acc and skips when it is zero, no flags changed.
// - bit test skip skips when the selected memory bit is zero and runs on when it is one.
// - specific page table read uses both table pointers, low byte to memory, high to latch.
// - current page table read uses current page and low pointer, low to memory, high to latch.
// - last page table read uses last page and low pointer, low to memory, high to latch.
// - xor to acc puts acc xor memory into acc and changes only the zero flag.
// - xor to memory writes memory xor acc back to memory and changes only the zero flag.
// - xor immediate puts acc xor immediate into acc and changes only the zero flag.
`timescale 1ns/1ps
module ssx_exec
   import ssx_pkg::*;
#(
   parameter int PADDR_W = 12,
   parameter int PROG_AW = 12,
   parameter int PROG_DW = 16
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // program memory read port
   output logic [PROG_AW-1:0] prog_addr,
   output logic prog_re,
   input wire logic [PROG_DW-1:0] prog_data,
   // pipeline status
   output logic skip_next,
   output logic busy
);
   localparam int PAGE_W = PROG_AW - 8;

   logic [7:0] acc, next_acc;
   logic [7:0] mem, next_mem;
   logic [7:0] tpl, next_tpl;
   logic [7:0] tph, next_tph;
   logic [7:0] tbh, next_tbh;
   logic [7:0] page, next_page;
   logic z, next_z;
   logic skip, next_skip;
   logic [PROG_AW-1:0] paddr_q, next_paddr_q;
   ssx_state_t state, next_state;
   ssx_op_t op, next_op;
   logic [2:0] bit_sel, next_bit_sel;
   logic [7:0] imm, next_imm;
   logic [31:0] next_prdata;

   logic [7:0] acc_res, mem_res;
   logic acc_we, mem_we, z_res, z_we, alu_skip;
   logic wr, rd, go;

   function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [11:0] off);
      hit = (a == PADDR_W'(off));
   endfunction

   ssx_alu u_alu (
      .op(op),
      .acc(acc),
      .mem(mem),
      .imm(imm),
      .bit_sel(bit_sel),
      .acc_res(acc_res),
      .acc_we(acc_we),
      .mem_res(mem_res),
      .mem_we(mem_we),
      .z_res(z_res),
      .z_we(z_we),
      .skip(alu_skip)
   );

   // single-cycle slave; error on unmapped address
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign go = wr && hit(paddr, SSX_CMD_OFF) && state == SSX_IDLE;
   assign skip_next = skip;
   assign busy = (state != SSX_IDLE);
   assign prog_addr = paddr_q;
   assign prog_re = (state == SSX_TABLE);

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         pslverr = !(hit(paddr, SSX_ACC_OFF) || hit(paddr, SSX_MEM_OFF) ||
            hit(paddr, SSX_TPL_OFF) || hit(paddr, SSX_TPH_OFF) ||
            hit(paddr, SSX_TBH_OFF) || hit(paddr, SSX_CMD_OFF) ||
            hit(paddr, SSX_STS_OFF) || hit(paddr, SSX_PAGE_OFF));
      end
   end

   always_comb begin
      next_prdata = prdata;
      if (rd) begin
         next_prdata = 32'h0000_0000;
         if (hit(paddr, SSX_ACC_OFF)) next_prdata[7:0] = acc;
         if (hit(paddr, SSX_MEM_OFF)) next_prdata[7:0] = mem;
         if (hit(paddr, SSX_TPL_OFF)) next_prdata[7:0] = tpl;
         if (hit(paddr, SSX_TPH_OFF)) next_prdata[7:0] = tph;
         if (hit(paddr, SSX_TBH_OFF)) next_prdata[7:0] = tbh;
         if (hit(paddr, SSX_PAGE_OFF)) next_prdata[7:0] = page;
         if (hit(paddr, SSX_STS_OFF)) begin
            next_prdata[SSX_ST_Z] = z;
            next_prdata[SSX_ST_SKIP] = skip;
            next_prdata[SSX_ST_BUSY] = busy;
         end
      end
   end

   always_comb begin
      next_acc = acc;
      next_mem = mem;
      next_tpl = tpl;
      next_tph = tph;
      next_tbh = tbh;
      next_page = page;
      next_z = z;
      next_skip = skip;
      next_paddr_q = paddr_q;
      next_state = state;
      next_op = op;
      next_bit_sel = bit_sel;
      next_imm = imm;
      // software writes outside a command
      if (wr && state == SSX_IDLE) begin
         if (hit(paddr, SSX_ACC_OFF)) next_acc = pwdata[7:0];
         if (hit(paddr, SSX_MEM_OFF)) next_mem = pwdata[7:0];
         if (hit(paddr, SSX_TPL_OFF)) next_tpl = pwdata[7:0];
         if (hit(paddr, SSX_TPH_OFF)) next_tph = pwdata[7:0];
         if (hit(paddr, SSX_PAGE_OFF)) next_page = pwdata[7:0];
      end
      case (state)
         SSX_IDLE: begin
            if (go) begin
               next_op = ssx_op_t'(pwdata[SSX_OP_LSB +: 4]);
               next_bit_sel = pwdata[SSX_BIT_LSB +: 3];
               next_imm = pwdata[SSX_IMM_LSB +: 8];
               next_skip = 1'b0;
               next_state = SSX_DUMMY;
               case (ssx_op_t'(pwdata[SSX_OP_LSB +: 4]))
                  SSX_TABLE_READ_SPECIFIC_PAGE: begin
                     next_paddr_q = {tph[PAGE_W-1:0], tpl};
                     next_state = SSX_TABLE;
                  end
                  SSX_TABLE_READ_CURRENT_PAGE: begin
                     next_paddr_q = {page[PAGE_W-1:0], tpl};
                     next_state = SSX_TABLE;
                  end
                  SSX_TABLE_READ_LAST_PAGE: begin
                     next_paddr_q = {{PAGE_W{1'b1}}, tpl};
                     next_state = SSX_TABLE;
                  end
                  default: begin
                     next_state = SSX_DUMMY;
                  end
               endcase
            end
         end
         SSX_DUMMY: begin
            // execute; a taken skip spends one more cycle in SSX_TABLE
            if (acc_we) next_acc = acc_res;
            if (mem_we) next_mem = mem_res;
            if (z_we) next_z = z_res;
            next_skip = alu_skip;
            next_op = SSX_NOP;
            next_state = alu_skip ? SSX_TABLE : SSX_IDLE;
            if (alu_skip) next_paddr_q = paddr_q;
         end
         SSX_TABLE: begin
            if (op == SSX_TABLE_READ_SPECIFIC_PAGE || op == SSX_TABLE_READ_CURRENT_PAGE ||
               op == SSX_TABLE_READ_LAST_PAGE) begin
               next_mem = prog_data[7:0];
               next_tbh = 8'(prog_data[PROG_DW-1:8]);
            end
            next_op = SSX_NOP;
            next_state = SSX_IDLE;
         end
         default: begin
            next_state = SSX_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= SSX_BYTE_RST;
         mem <= SSX_BYTE_RST;
         tpl <= SSX_BYTE_RST;
         tph <= SSX_BYTE_RST;
         tbh <= SSX_BYTE_RST;
         page <= SSX_BYTE_RST;
         z <= 1'b0;
         skip <= 1'b0;
         paddr_q <= '0;
         state <= SSX_IDLE;
         op <= SSX_NOP;
         bit_sel <= 3'h0;
         imm <= SSX_BYTE_RST;
         prdata <= 32'h0000_0000;
      end else begin
         acc <= next_acc;
         mem <= next_mem;
         tpl <= next_tpl;
         tph <= next_tph;
         tbh <= next_tbh;
         page <= next_page;
         z <= next_z;
         skip <= next_skip;
         paddr_q <= next_paddr_q;
         state <= next_state;
         op <= next_op;
         bit_sel <= next_bit_sel;
         imm <= next_imm;
         prdata <= next_prdata;
      end
   end
endmodule

/* bench/ssx_exec_monitor.sv */
/*
 ssx_exec_monitor: port checks for the execution block, bound to ssx_exec.
 assumes zero wait apb; shadows the pointer and command writes it sees.
*/
`timescale 1ns/1ps
module ssx_exec_monitor
   import ssx_pkg::*;
#(
   parameter int PADDR_W = 12,
   parameter int PROG_AW = 12
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // program port and status
   input wire logic [PROG_AW-1:0] prog_addr,
   input wire logic prog_re,
   input wire logic skip_next,
   input wire logic busy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] tpl, tph, pg, next_tpl, next_tph, next_pg;
   logic [3:0] op, next_op;
   logic w;
   // writes while busy are refused, so the shadow skips them too
   assign w = psel && penable && pwrite && !busy;
   always_comb begin
      next_tpl = (w && paddr == SSX_TPL_OFF) ? pwdata[7:0] : tpl;
      next_tph = (w && paddr == SSX_TPH_OFF) ? pwdata[7:0] : tph;
      next_pg = (w && paddr == SSX_PAGE_OFF) ? pwdata[7:0] : pg;
      next_op = (w && paddr == SSX_CMD_OFF) ? pwdata[3:0] : op;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tpl, tph, pg, op} <= '0;
      end else begin
         {tpl, tph, pg, op} <= {next_tpl, next_tph, next_pg, next_op};
      end
   end
   sequence fetch_s;
      busy && prog_re ##1 !busy;
   endsequence
   skip_cost_a: assert property ($rose(skip_next) |-> fetch_s)
      else $error("taken skip without one dummy cycle");
   busy_len_a: assert property ($rose(busy) |-> ##[1:2] !busy)
      else $error("command busy too long");
   fetch_busy_a: assert property (prog_re |-> busy)
      else $error("program fetch outside a command");
   skip_cause_a: assert property ($rose(skip_next)
      |-> op inside {4'h2, 4'h3, 4'h4}) else $error("skip from a non skip command");
   table_fetch_a: assert property ($rose(busy) && op inside {4'h5, 4'h6, 4'h7}
      |-> fetch_s) else $error("table read without one fetch cycle");
   spec_addr_a: assert property (prog_re && op == 4'h5
      |-> prog_addr == PROG_AW'({tph, tpl})) else $error("specific page address wrong");
   cur_addr_a: assert property (prog_re && op == 4'h6
      |-> prog_addr == PROG_AW'({pg, tpl})) else $error("current page address wrong");
   last_addr_a: assert property (prog_re && op == 4'h7
      |-> prog_addr == PROG_AW'({8'hFF, tpl})) else $error("last page address wrong");
   alu_one_a: assert property ($rose(busy) && op inside {4'h1, 4'h8, 4'h9, 4'hA}
      |=> !busy) else $error("swap or xor took more than one cycle");
endmodule
bind ssx_exec ssx_exec_monitor #(.PADDR_W(PADDR_W), .PROG_AW(PROG_AW)) ssx_exec_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prog_addr(prog_addr), .prog_re(prog_re),
   .skip_next(skip_next), .busy(busy)
);

/* bench/testbench.sv */
/*
 testbench: apb register tests of ssx_exec.
 assumes zero wait states; program words are a fixed function of address.
*/
`timescale 1ns/1ps
module testbench
   import ssx_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, prog_re, skip_next, busy, e;
   logic [11:0] prog_addr;
   logic [15:0] prog_data;
   logic [7:0] pg;
   int num_errors = 0, checks = 0, cyc = 0;
   // high byte carries the page so a wrong page shows in the latch
   assign prog_data = {4'hC, prog_addr[11:8], prog_addr[7:0] ^ 8'h3C};
   ssx_exec ssx_exec_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_re(prog_re), .prog_data(prog_data),
      .skip_next(skip_next), .busy(busy)
   );
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // acc and mem are rewritten each time; the zero flag carries into the next case
   task automatic run(input logic [7:0] acc, input logic [7:0] mem, input logic [31:0] cmd,
         input int n);
      int k;
      apb(1'b1, SSX_ACC_OFF, {24'h0, acc});
      apb(1'b1, SSX_MEM_OFF, {24'h0, mem});
      apb(1'b1, SSX_CMD_OFF, cmd);
      k = 0;
      @(posedge pclk);
      while (busy === 1'b1 && k < 4) begin
         k++;
         @(posedge pclk);
      end
      chk(k, n);
   endtask
   task automatic print_verdict;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rc(SSX_STS_OFF, 32'h0);
      rc(SSX_TBH_OFF, 32'h0);
      run(8'h5A, 8'h5A, 32'h8, 1);
      rc(SSX_ACC_OFF, 32'h0);
      rc(SSX_STS_OFF, 32'h1);
      run(8'h00, 8'hA7, 32'h1, 1);
      rc(SSX_ACC_OFF, 32'h7A);
      rc(SSX_MEM_OFF, 32'hA7);
      rc(SSX_STS_OFF, 32'h1);
      run(8'h7A, 8'h00, 32'h0F0A, 1);
      rc(SSX_ACC_OFF, 32'h75);
      rc(SSX_STS_OFF, 32'h0);
      run(8'h75, 8'hA7, 32'h9, 1);
      rc(SSX_MEM_OFF, 32'hD2);
      rc(SSX_ACC_OFF, 32'h75);
      run(8'h33, 8'h00, 32'h2, 2);
      chk({31'h0, skip_next}, 32'h1);
      rc(SSX_STS_OFF, 32'h2);
      run(8'h33, 8'h01, 32'h2, 1);
      chk({31'h0, skip_next}, 32'h0);
      rc(SSX_STS_OFF, 32'h0);
      run(8'h33, 8'h00, 32'h3, 2);
      rc(SSX_ACC_OFF, 32'h0);
      rc(SSX_STS_OFF, 32'h2);
      run(8'h33, 8'h80, 32'h3, 1);
      rc(SSX_ACC_OFF, 32'h80);
      for (int i = 0; i < 8; i++) begin
         run(8'h00, ~(8'h01 << i), 32'h4 | (i << 4), 2);
         run(8'h00, 8'h01 << i, 32'h4 | (i << 4), 1);
      end
      apb(1'b1, SSX_TPL_OFF, 32'h96);
      apb(1'b1, SSX_TPH_OFF, 32'h05);
      apb(1'b1, SSX_PAGE_OFF, 32'h0B);
      for (int p = 0; p < 3; p++) begin
         pg = p == 0 ? 8'h05 : p == 1 ? 8'h0B : 8'hFF;
         run(8'h00, 8'h00, 32'h5 + p, 1);
         rc(SSX_MEM_OFF, 32'hAA);
         rc(SSX_TBH_OFF, {24'h0, 4'hC, pg[3:0]});
      end
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, e}, 32'h1);
      print_verdict();
   end
endmodule
